// [design/cic_pkg.sv]
// constants and types of the cascaded interrupt controller pair
package cic_pkg;
    // ****************************************
    // i/o port map
    // ****************************************
    localparam logic [15:0] CIC_PRI_BASE        = 16'h0020;
    localparam logic [15:0] CIC_PRI_DATA        = 16'h0021;
    localparam logic [15:0] CIC_SEC_BASE        = 16'h00a0;
    localparam logic [15:0] CIC_SEC_DATA        = 16'h00a1;
    localparam logic [15:0] CIC_TRIG_PORT       = 16'h04d0;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  CIC_PRI_CASCADE_RST = 8'h04;
    localparam logic [7:0]  CIC_SEC_CASCADE_RST = 8'h02;
    localparam logic [7:0]  CIC_TRIG_RST        = 8'h00;
    localparam logic [7:0]  CIC_MASK_RST        = 8'hff;
    localparam logic [7:0]  CIC_MODE_RST        = 8'h01;
    localparam logic [4:0]  CIC_VBASE_RST       = 5'h00;
    // ****************************************
    // field positions and codes
    // ****************************************
    localparam int          CIC_INIT_BIT        = 4;
    localparam int          CIC_CMD_SEL_BIT     = 3;
    localparam int          CIC_EOI_BIT         = 5;
    localparam int          CIC_SPEC_BIT        = 6;
    localparam int          CIC_AUTO_END_BIT    = 1;
    localparam logic [2:0]  CIC_CASCADE_LINE    = 3'h2;
    localparam logic [2:0]  CIC_SPURIOUS        = 3'h7;
    // ****************************************
    // state machines
    // ****************************************
    typedef enum logic [3:0] {
        INIT_READY = 4'b0001,
        INIT_VEC   = 4'b0010,
        INIT_CAS   = 4'b0100,
        INIT_MODE  = 4'b1000
    } cic_init_t;
    typedef enum logic [3:0] {
        ACK_IDLE = 4'b0001,
        ACK_P1   = 4'b0010,
        ACK_GAP  = 4'b0100,
        ACK_P2   = 4'b1000
    } cic_ack_t;
endpackage

// [design/cic_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module cic_sync #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    // pins in, synchronised out
    input  wire logic [W-1:0]  i_async,
    output logic      [W-1:0]  o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cic_sync_t;

    cic_sync_t s_q;
    cic_sync_t s_d;

    always_comb begin
        s_d.s1 = i_async;
        s_d.s2 = s_q.s1;
        if (!i_rst_n) begin
            s_d.s1 = RST_VAL;
            s_d.s2 = RST_VAL;
        end
    end

    always_ff @(posedge i_clk) begin
        s_q <= s_d;
    end

    assign o_sync = s_q.s2;
endmodule

// [design/cic_top.sv]
// cascaded pair of interrupt controllers: init, mask, trigger select, acknowledge
// How it works
// - a base-port write with bit 4 set starts init, then three data-port writes load vector base, cascade word and mode word in order.
// - the acknowledge vector carries the vector base in bits 7:3 and the serviced level in bits 2:0.
// - the primary cascade word resets to 04h, software keeps only bit 2 set, and line 2 is the secondary's output.
// - the primary drives the identity code from the end of the first strobe pulse to the end of the second, and the secondary compares it with its own code.
// - with the auto end bit set, the in-service bit clears by itself at the end of the acknowledge.
// - a one in the mask word masks that line, a zero unmasks it, and the mask word reads back.
// - after init each line's mask may be changed at any time independently.
// - masking line 2 on the primary blocks every secondary request.
// - trigger select is one 8-bit word shared by both controllers, resets to 00h, and zero means edge except on primary cascade lines.
`timescale 1ns/1ns
module cic_top (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    // i/o port access
    input  wire logic [15:0] I_IO_ADDR,
    input  wire logic        I_IO_WR,
    input  wire logic        I_IO_RD,
    input  wire logic [7:0]  I_IO_WDATA,
    output logic      [7:0]  O_IO_RDATA,
    // request pins and acknowledge strobe
    input  wire logic [15:0] I_IRQ,
    input  wire logic        I_ACK_STROBE_N,
    // toward the processor
    output logic             O_INTR,
    output logic      [7:0]  O_VECTOR,
    output logic             O_VECTOR_VALID,
    // cascade identity bus and secondary request
    output logic      [2:0]  O_CAS_ID,
    output logic             O_CAS_OE,
    output logic             O_SEC_INTR
);
    import cic_pkg::*;

    typedef struct packed {
        cic_init_t [1:0]       init;
        logic [1:0][4:0]       vbase;
        logic [1:0][7:0]       cascade;
        logic [1:0][7:0]       mode;
        logic [1:0][7:0]       mask;
        logic [1:0][7:0]       irr;
        logic [1:0][7:0]       isr;
        logic [1:0][7:0]       prev;
        logic [1:0][2:0]       lvl;
        logic [7:0]            trig;
        cic_ack_t              ack;
        logic                  ack_prev;
        logic [1:0]            resp;
        logic [2:0]            cas;
        logic                  cas_oe;
        logic [7:0]            vector;
        logic                  vvalid;
        logic [7:0]            rdata;
        logic                  intr;
        logic                  sec_intr;
    } cic_state_t;

    cic_state_t              s_q;
    cic_state_t              s_d;
    logic [16:0]             pins_s;
    logic [15:0]             irq_s;
    logic                    ack_n_s;
    logic                    lead;
    logic                    trail;
    logic [1:0][7:0]         raw;
    logic [1:0][7:0]         lvl_mode;
    logic [1:0][7:0]         pend;
    logic [1:0][3:0]         fp;
    logic [1:0][3:0]         fs;
    logic [1:0]              intr_c;
    logic [1:0]              wr_base;
    logic [1:0]              wr_data;
    logic [1:0][7:0]         clr_isr;
    logic [1:0][7:0]         set_isr;
    logic [1:0][7:0]         clr_irr;
    logic [2:0]              sec_lvl;

    // ****************************************
    // pin synchronisers
    // ****************************************
    cic_sync #(
        .W       (17),
        .RST_VAL (17'h10000)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_async ({I_ACK_STROBE_N, I_IRQ}),
        .o_sync  (pins_s)
    );
    assign irq_s   = pins_s[15:0];
    assign ack_n_s = pins_s[16];

    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d        = s_q;
        lead       = s_q.ack_prev & ~ack_n_s;
        trail      = ~s_q.ack_prev & ack_n_s;
        s_d.ack_prev = ack_n_s;
        raw[0]     = {irq_s[7:3], s_q.sec_intr, irq_s[1:0]};
        raw[1]     = irq_s[15:8];
        lvl_mode[0] = s_q.trig | s_q.cascade[0];
        lvl_mode[1] = s_q.trig;
        clr_isr    = '0;
        set_isr    = '0;
        clr_irr    = '0;
        sec_lvl    = CIC_SPURIOUS;
        for (int c = 0; c < 2; c++) begin
            pend[c]    = (lvl_mode[c] & raw[c]) | (~lvl_mode[c] & s_q.irr[c]);
            fp[c]      = first_set(pend[c] & ~s_q.mask[c]);
            fs[c]      = first_set(s_q.isr[c]);
            intr_c[c]  = fp[c][3] & (~fs[c][3] | (fp[c][2:0] < fs[c][2:0]));
            wr_base[c] = I_IO_WR & (I_IO_ADDR == (c == 1 ? CIC_SEC_BASE : CIC_PRI_BASE));
            wr_data[c] = I_IO_WR & (I_IO_ADDR == (c == 1 ? CIC_SEC_DATA : CIC_PRI_DATA));
            s_d.prev[c] = raw[c];
            // base port: init start or end-of-service commands
            if (wr_base[c] && I_IO_WDATA[CIC_INIT_BIT]) begin
                s_d.init[c] = INIT_VEC;
                clr_isr[c]  = 8'hff;
                clr_irr[c]  = 8'hff;
            end else if (wr_base[c] && !I_IO_WDATA[CIC_CMD_SEL_BIT] && I_IO_WDATA[CIC_EOI_BIT]) begin
                if (I_IO_WDATA[CIC_SPEC_BIT]) begin
                    clr_isr[c][I_IO_WDATA[2:0]] = 1'b1;
                end else if (fs[c][3]) begin
                    clr_isr[c][fs[c][2:0]] = 1'b1;
                end
            end
            // data port: init sequence, then the mask word
            if (wr_data[c]) begin
                case (s_q.init[c])
                    INIT_VEC: begin
                        s_d.vbase[c] = I_IO_WDATA[7:3];
                        s_d.init[c]  = INIT_CAS;
                    end
                    INIT_CAS: begin
                        s_d.cascade[c] = I_IO_WDATA;
                        s_d.init[c]    = INIT_MODE;
                    end
                    INIT_MODE: begin
                        s_d.mode[c] = I_IO_WDATA;
                        s_d.init[c] = INIT_READY;
                    end
                    INIT_READY: begin
                        s_d.mask[c] = I_IO_WDATA;
                    end
                    default: begin
                        s_d.init[c] = INIT_READY;
                    end
                endcase
            end
        end
        if (I_IO_WR && I_IO_ADDR == CIC_TRIG_PORT) begin
            s_d.trig = I_IO_WDATA;
        end
        if (s_q.cas_oe && s_q.cas == s_q.cascade[1][2:0] && fp[1][3]) begin
            sec_lvl = fp[1][2:0];
        end
        // ****************************************
        // acknowledge sequence
        // ****************************************
        case (s_q.ack)
            ACK_IDLE: begin
                if (lead) begin
                    s_d.lvl[0] = fp[0][3] ? fp[0][2:0] : CIC_SPURIOUS;
                    s_d.resp   = 2'b01;
                    if (fp[0][3]) begin
                        set_isr[0][fp[0][2:0]] = 1'b1;
                        clr_irr[0][fp[0][2:0]] = 1'b1;
                        if (s_q.cascade[0][fp[0][2:0]]) begin
                            s_d.resp = 2'b10;
                        end
                    end
                    s_d.ack = ACK_P1;
                end
            end
            ACK_P1: begin
                if (trail) begin
                    if (s_q.resp[1]) begin
                        s_d.cas    = s_q.lvl[0];
                        s_d.cas_oe = 1'b1;
                    end
                    s_d.ack = ACK_GAP;
                end
            end
            ACK_GAP: begin
                if (lead) begin
                    if (s_q.resp[1]) begin
                        s_d.lvl[1] = sec_lvl;
                        if (s_q.cas_oe && s_q.cas == s_q.cascade[1][2:0] && fp[1][3]) begin
                            set_isr[1][sec_lvl] = 1'b1;
                            clr_irr[1][sec_lvl] = 1'b1;
                        end
                        s_d.vector = {s_q.vbase[1], sec_lvl};
                    end else begin
                        s_d.vector = {s_q.vbase[0], s_q.lvl[0]};
                    end
                    s_d.vvalid = 1'b1;
                    s_d.ack    = ACK_P2;
                end
            end
            ACK_P2: begin
                if (trail) begin
                    if (s_q.mode[0][CIC_AUTO_END_BIT]) begin
                        clr_isr[0][s_q.lvl[0]] = 1'b1;
                    end
                    if (s_q.resp[1] && s_q.mode[1][CIC_AUTO_END_BIT]) begin
                        clr_isr[1][s_q.lvl[1]] = 1'b1;
                    end
                    s_d.vvalid = 1'b0;
                    s_d.vector = 8'h00;
                    s_d.cas_oe = 1'b0;
                    s_d.cas    = 3'h0;
                    s_d.ack    = ACK_IDLE;
                end
            end
            default: begin
                s_d.ack = ACK_IDLE;
            end
        endcase
        // set wins over clear for both in-service and request bits
        for (int c = 0; c < 2; c++) begin
            s_d.isr[c] = (s_q.isr[c] & ~clr_isr[c]) | set_isr[c];
            s_d.irr[c] = ((s_q.irr[c] & ~clr_irr[c]) | (raw[c] & ~s_q.prev[c]))
                         & ~lvl_mode[c];
        end
        s_d.intr     = intr_c[0];
        s_d.sec_intr = intr_c[1];
        if (I_IO_RD) begin
            case (I_IO_ADDR)
                CIC_PRI_DATA:  s_d.rdata = s_q.mask[0];
                CIC_SEC_DATA:  s_d.rdata = s_q.mask[1];
                CIC_TRIG_PORT: s_d.rdata = s_q.trig;
                default:       s_d.rdata = 8'h00;
            endcase
        end
        if (!I_RST_N) begin
            s_d          = '0;
            s_d.init[0]  = INIT_READY;
            s_d.init[1]  = INIT_READY;
            s_d.vbase    = {CIC_VBASE_RST, CIC_VBASE_RST};
            s_d.cascade  = {CIC_SEC_CASCADE_RST, CIC_PRI_CASCADE_RST};
            s_d.mode     = {CIC_MODE_RST, CIC_MODE_RST};
            s_d.mask     = {CIC_MASK_RST, CIC_MASK_RST};
            s_d.trig     = CIC_TRIG_RST;
            s_d.ack      = ACK_IDLE;
            s_d.ack_prev = 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        s_q <= s_d;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign O_IO_RDATA     = s_q.rdata;
    assign O_INTR         = s_q.intr;
    assign O_VECTOR       = s_q.vector;
    assign O_VECTOR_VALID = s_q.vvalid;
    assign O_CAS_ID       = s_q.cas;
    assign O_CAS_OE       = s_q.cas_oe;
    assign O_SEC_INTR     = s_q.sec_intr;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    a_init_start: assert property ((I_IO_WR && I_IO_ADDR == CIC_PRI_BASE && I_IO_WDATA[4])
        |=> s_q.init[0] == INIT_VEC) else $error("init start not taken");
    a_vector_build: assert property ((s_q.ack == ACK_GAP && lead && s_q.resp[0])
        |=> O_VECTOR_VALID && O_VECTOR == {s_q.vbase[0], s_q.lvl[0]})
        else $error("vector does not match base and level");
    a_cascade_reset: assert property ($past(!I_RST_N) |-> s_q.cascade[0] == 8'h04)
        else $error("cascade word reset wrong");
    a_cas_window: assert property ((s_q.ack == ACK_GAP && s_q.resp[1])
        |-> O_CAS_OE && O_CAS_ID == 3'h2) else $error("identity not driven");
    a_cas_release: assert property ((s_q.ack == ACK_P2 && trail) |=> !O_CAS_OE && !O_VECTOR_VALID)
        else $error("identity held after second pulse");
    a_auto_end: assert property ((s_q.ack == ACK_P2 && trail && s_q.mode[0][1])
        |=> !s_q.isr[0][$past(s_q.lvl[0])]) else $error("auto end missed");
    a_mask_write: assert property ((I_IO_WR && I_IO_ADDR == CIC_PRI_DATA
        && s_q.init[0] == INIT_READY) |=> s_q.mask[0] == $past(I_IO_WDATA))
        else $error("mask write lost");
    a_mask_read: assert property ((I_IO_RD && I_IO_ADDR == CIC_SEC_DATA)
        |=> O_IO_RDATA == $past(s_q.mask[1])) else $error("mask read wrong");
    a_line2_block: assert property ((s_q.ack == ACK_IDLE && lead && s_q.mask[0][2])
        |=> !s_q.resp[1]) else $error("masked cascade line serviced");
    a_trig_reset: assert property ($past(!I_RST_N) |-> s_q.trig == 8'h00)
        else $error("trigger select reset wrong");
    a_edge_catch: assert property ((!s_q.trig[4] && irq_s[4] && !s_q.prev[0][4])
        |=> s_q.irr[0][4]) else $error("edge request lost");
    a_level_raise: assert property ((s_q.trig[3] && irq_s[3] && !s_q.mask[0][3]
        && s_q.isr[0] == 8'h00) |=> O_INTR) else $error("level request not raised");

    c_primary_ack: cover property (s_q.vvalid && s_q.resp[0]);
    c_secondary_ack: cover property (s_q.vvalid && s_q.resp[1]);
    c_init_done: cover property (s_q.init[1] == INIT_MODE ##[1:50] s_q.init[1] == INIT_READY);
endmodule

// [dv/cic_host.sv]
// host processor model: i/o port cycles and interrupt acknowledge
`timescale 1ns/1ns
module cic_host (
    // clock
    input  wire logic        i_clk,
    // i/o port access
    output logic      [15:0] o_io_addr,
    output logic             o_io_wr,
    output logic             o_io_rd,
    output logic      [7:0]  o_io_wdata,
    input  wire logic [7:0]  i_io_rdata,
    // acknowledge link
    output logic             o_ack_strobe_n,
    input  wire logic [7:0]  i_vector,
    input  wire logic        i_vector_valid,
    input  wire logic [2:0]  i_cas_id,
    input  wire logic        i_cas_oe
);
    initial begin
        o_io_addr      = 16'h0000;
        o_io_wr        = 1'b0;
        o_io_rd        = 1'b0;
        o_io_wdata     = 8'h00;
        o_ack_strobe_n = 1'b1;
    end
    // ****************************************
    // port cycles, released bus shows inverted value
    // ****************************************
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        #1;
        o_io_addr  = addr;
        o_io_wdata = data;
        o_io_wr    = 1'b1;
        @(posedge i_clk);
        #1;
        o_io_wr    = 1'b0;
        o_io_addr  = ~addr;
        o_io_wdata = ~data;
    endtask
    task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
        @(posedge i_clk);
        #1;
        o_io_addr = addr;
        o_io_rd   = 1'b1;
        @(posedge i_clk);
        #1;
        o_io_rd   = 1'b0;
        o_io_addr = ~addr;
        data      = i_io_rdata;
    endtask
    // start word, vector base, cascade word, mode word in that order
    task automatic init_ctl(input logic [15:0] base, input logic [7:0] vbase,
                            input logic [7:0] cas, input logic auto_end);
        io_write(base, 8'h11);
        io_write(base + 16'h0001, vbase);
        io_write(base + 16'h0001, cas);
        io_write(base + 16'h0001, {3'b000, 1'b0, 1'b0, 1'b0, auto_end, 1'b1});
    endtask
    // ****************************************
    // two strobe pulses, sampled late in the second
    // ****************************************
    task automatic acknowledge(output logic [7:0] vec, output logic [2:0] cas,
                               output logic [1:0] mid, output logic [1:0] fin);
        @(posedge i_clk);
        #1 o_ack_strobe_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #1 o_ack_strobe_n = 1'b1;
        repeat (6) @(posedge i_clk);
        #1 o_ack_strobe_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        vec = i_vector;
        cas = i_cas_id;
        mid = {i_cas_oe, i_vector_valid};
        o_ack_strobe_n = 1'b1;
        repeat (6) @(posedge i_clk);
        #1;
        fin = {i_cas_oe, i_vector_valid};
    endtask
endmodule

// [dv/cic_top_test.sv]
// self-checking bench of the cascaded interrupt controller pair
`timescale 1ns/1ns
module cic_top_test;
    import cic_pkg::*;
    logic        clk;
    logic        rst_n;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic [15:0] irq;
    logic        ack_n;
    logic        o_intr;
    logic [7:0]  o_vector;
    logic        o_vector_valid;
    logic [2:0]  o_cas_id;
    logic        o_cas_oe;
    logic        o_sec_intr;
    logic [7:0]  rd;
    logic [7:0]  vec;
    logic [2:0]  cas;
    logic [1:0]  mid;
    logic [1:0]  fin;
    int          fail_count;
    int          checked;
    int          cycles;

    cic_top i_cic_top (.I_CLK(clk), .I_RST_N(rst_n), .I_IO_ADDR(io_addr), .I_IO_WR(io_wr),
        .I_IO_RD(io_rd), .I_IO_WDATA(io_wdata), .O_IO_RDATA(io_rdata), .I_IRQ(irq),
        .I_ACK_STROBE_N(ack_n), .O_INTR(o_intr), .O_VECTOR(o_vector),
        .O_VECTOR_VALID(o_vector_valid), .O_CAS_ID(o_cas_id), .O_CAS_OE(o_cas_oe),
        .O_SEC_INTR(o_sec_intr));
    cic_host i_cic_host (.i_clk(clk), .o_io_addr(io_addr), .o_io_wr(io_wr), .o_io_rd(io_rd),
        .o_io_wdata(io_wdata), .i_io_rdata(io_rdata), .o_ack_strobe_n(ack_n),
        .i_vector(o_vector), .i_vector_valid(o_vector_valid), .i_cas_id(o_cas_id),
        .i_cas_oe(o_cas_oe));
    // ****************************************
    // clock and hang guard
    // ****************************************
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_cic_host.io_write(a, d);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input string what);
        i_cic_host.io_read(a, rd);
        chk(rd, exp, what);
    endtask
    // reach: seen within 12 cycles; stay: held for all 12
    task automatic line(input bit sec, input logic exp, input bit stay, input string what);
        logic v;
        logic ok;
        ok = stay;
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            #1;
            v = sec ? o_sec_intr : o_intr;
            if (stay && v !== exp) ok = 1'b0;
            if (!stay && v === exp) ok = 1'b1;
        end
        chk({7'h00, ok}, 8'h01, what);
    endtask
    task automatic ack_chk(input logic [7:0] ev, input logic [1:0] em, input string what);
        i_cic_host.acknowledge(vec, cas, mid, fin);
        chk(vec, ev, what);
        chk({6'h00, mid}, {6'h00, em}, what);
        chk({6'h00, fin}, 8'h00, what);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        irq = 16'h0000;
        fail_count = 0;
        checked = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        chk({4'h0, o_intr, o_sec_intr, o_vector_valid, o_cas_oe}, 8'h00, "reset outs");
        rdc(CIC_PRI_DATA, CIC_MASK_RST, "pri mask rst");
        rdc(CIC_SEC_DATA, CIC_MASK_RST, "sec mask rst");
        rdc(CIC_TRIG_PORT, 8'h00, "trig rst");
        rdc(CIC_PRI_BASE, 8'h00, "base read");
        rdc(16'h0300, 8'h00, "unmapped read");
        $display("test reset done");
        i_cic_host.init_ctl(CIC_PRI_BASE, 8'h08, 8'h04, 1'b0);
        i_cic_host.init_ctl(CIC_SEC_BASE, 8'h70, 8'h02, 1'b0);
        rdc(CIC_PRI_DATA, CIC_MASK_RST, "init kept mask");
        rdc(CIC_SEC_DATA, CIC_MASK_RST, "init kept mask");
        $display("test init done");
        for (int p = 0; p < 2; p++) begin
            wr(CIC_PRI_DATA, p ? 8'ha5 : 8'h5a);
            wr(CIC_SEC_DATA, p ? 8'h5a : 8'ha5);
            rdc(CIC_PRI_DATA, p ? 8'ha5 : 8'h5a, "pri mask rw");
            rdc(CIC_SEC_DATA, p ? 8'h5a : 8'ha5, "sec mask rw");
        end
        wr(16'h0300, 8'h00);
        rdc(CIC_PRI_DATA, 8'ha5, "unmapped write");
        $display("test mask done");
        wr(CIC_PRI_DATA, 8'hf7);
        wr(CIC_SEC_DATA, 8'hff);
        @(posedge clk);
        #1 irq[3] = 1'b1;
        irq[4] = 1'b1;
        line(0, 1'b1, 0, "edge req");
        ack_chk(8'h0b, 2'b01, "vector 3");
        wr(CIC_PRI_BASE, 8'h20);
        line(0, 1'b0, 1, "masked 4");
        wr(CIC_PRI_DATA, 8'he7);
        line(0, 1'b1, 0, "unmasked 4");
        ack_chk(8'h0c, 2'b01, "vector 4");
        wr(CIC_PRI_BASE, 8'h20);
        irq[4:3] = 2'b00;
        $display("test primary done");
        wr(CIC_PRI_DATA, 8'hfb);
        wr(CIC_SEC_DATA, 8'hdf);
        @(posedge clk);
        #1 irq[13] = 1'b1;
        line(1, 1'b1, 0, "sec intr");
        line(0, 1'b1, 0, "cascade intr");
        ack_chk(8'h75, 2'b11, "vector 13");
        chk({5'h00, cas}, {5'h00, CIC_CASCADE_LINE}, "cas id");
        wr(CIC_SEC_BASE, 8'h65);
        wr(CIC_PRI_BASE, 8'h20);
        irq[13] = 1'b0;
        wr(CIC_SEC_DATA, 8'h00);
        wr(CIC_PRI_DATA, 8'h04);
        @(posedge clk);
        #1 irq[14] = 1'b1;
        line(1, 1'b1, 0, "sec intr 14");
        line(0, 1'b0, 1, "line2 masked");
        wr(CIC_PRI_DATA, 8'h00);
        line(0, 1'b1, 0, "line2 unmasked");
        ack_chk(8'h76, 2'b11, "vector 14");
        wr(CIC_SEC_BASE, 8'h20);
        wr(CIC_PRI_BASE, 8'h20);
        irq[14] = 1'b0;
        $display("test cascade done");
        wr(CIC_TRIG_PORT, 8'h08);
        rdc(CIC_TRIG_PORT, 8'h08, "trig rw");
        @(posedge clk);
        #1 irq[3] = 1'b1;
        i_cic_host.init_ctl(CIC_PRI_BASE, 8'h08, 8'h04, 1'b1);
        wr(CIC_PRI_DATA, 8'hf7);
        line(0, 1'b1, 0, "level req");
        ack_chk(8'h0b, 2'b01, "level vector");
        line(0, 1'b1, 0, "auto end again");
        @(posedge clk);
        #1 irq[3] = 1'b0;
        line(0, 1'b0, 0, "level dropped");
        ack_chk(8'h0f, 2'b01, "no request");
        $display("test level done");
        tally_and_finish();
    end
endmodule
